//--- include/nvm_pkg.sv
package nvm_pkg;

  // clock rate and the erase / program stall
  localparam int unsigned CLK_MHZ        = 100;           // aclk rate in MHz
  localparam int unsigned ERASE_TIME_US  = 2000;          // typical 2 ms halt
  localparam int unsigned BUSY_CYCLES    = ERASE_TIME_US * CLK_MHZ;
  localparam int          COUNT_W        = 18;            // holds BUSY_CYCLES

  // geometry of words, addresses, rows and latches
  localparam int          WORD_W         = 14;            // flash word width
  localparam int          ADDR_LOW_W     = 8;
  localparam int          ADDR_HIGH_W    = 7;
  localparam int          DATA_LOW_W     = 8;
  localparam int          DATA_HIGH_W    = 6;
  localparam int          ARRAY_WORDS    = 256;           // words held on chip
  localparam int          ROW_WORDS      = 32;            // erase row, bits 4:0
  localparam int          ROW_SHIFT      = 5;
  localparam int          LATCHES        = 8;             // write latches, bits 2:0
  localparam int          LATCH_SHIFT    = 3;

  typedef logic [WORD_W-1:0] word_t;
  localparam word_t       ERASED_WORD    = 14'h3fff;

  // register byte offsets
  localparam logic [11:0] OFS_ADDR_LOW   = 12'h000;
  localparam logic [11:0] OFS_ADDR_HIGH  = 12'h004;
  localparam logic [11:0] OFS_DATA_LOW   = 12'h008;
  localparam logic [11:0] OFS_DATA_HIGH  = 12'h00c;
  localparam logic [11:0] OFS_CONTROL    = 12'h010;
  localparam logic [11:0] OFS_UNLOCK     = 12'h014;
  localparam logic [11:0] OFS_STATUS     = 12'h018;

  // nvm_control bit positions
  localparam int          CTL_READ       = 0;             // read trigger
  localparam int          CTL_LAUNCH     = 1;             // erase / program launch
  localparam int          CTL_PERMIT     = 2;             // store_permit
  localparam int          CTL_ERASE      = 3;             // row erase select
  localparam int          CTL_LATCH_ONLY = 4;             // latch_only_mode
  localparam int          CTL_CFG        = 5;             // config_space_select
  localparam int          CTL_PROG       = 6;             // program_space_select
  localparam int          CTL_W          = 7;
  localparam logic [6:0]  CTL_RESET      = 7'h00;

  // status bit positions
  localparam int          ST_DONE        = 0;             // nvm_done_flag, write 1 clears
  localparam int          ST_BUSY        = 1;
  localparam int          ST_PROTECT     = 2;

  // unlock keys
  localparam logic [7:0]  UNLOCK_KEY1    = 8'h55;
  localparam logic [7:0]  UNLOCK_KEY2    = 8'haa;
  localparam logic [1:0]  KEY_NONE       = 2'h0;
  localparam logic [1:0]  KEY_FIRST      = 2'h1;
  localparam logic [1:0]  KEY_ARMED      = 2'h2;

  // axi responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // sequencer states, gray along read and erase/program paths
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_RD_WAIT = 3'h1,
    ST_RD_DO  = 3'h3,
    ST_SETUP1 = 3'h2,
    ST_SETUP2 = 3'h6,
    ST_WORK   = 3'h7,
    ST_FINISH = 3'h5
  } seq_state_e;

endpackage

//--- include/nvm_if.sv
`timescale 1ns/1ps
interface nvm_if import nvm_pkg::*; ();
  logic [ADDR_LOW_W-1:0]      word_addr;   // low address byte
  word_t                      rd_data;     // array word at word_addr
  logic                       erase_go;    // erase the row of word_addr
  logic                       prog_go;     // program the latch block
  logic                       latch_load;  // load one latch from latch_data
  logic                       latch_clear; // return every latch to erased
  word_t                      latch_data;  // data pair contents
  logic [LATCHES-1:0][WORD_W-1:0] latches; // latch block contents

  modport ctrl  (output word_addr, erase_go, prog_go, latch_load, latch_clear, latch_data,
                 input rd_data);
  modport latch (input word_addr, latch_load, latch_clear, latch_data, output latches);
  modport array (input word_addr, erase_go, prog_go, latches, output rd_data);
endinterface

//--- hdl/write_latch_bank.sv
`timescale 1ns/1ps
module write_latch_bank import nvm_pkg::*; (
  input  wire logic aclk,
  input  wire logic aresetn,
  nvm_if.latch      bus
);

  typedef struct packed {
    logic [LATCHES-1:0][WORD_W-1:0] latch; // write latch contents
  } bank_s;

  bank_s s;      // registered state
  bank_s next_s; // next state

  // one latch loads per launch; clear after programming wins over load
  always_comb begin
    next_s = s;
    for (int i = 0; i < LATCHES; i++) begin
      if (bus.latch_clear) begin
        next_s.latch[i] = ERASED_WORD;
      end else if (bus.latch_load && bus.word_addr[LATCH_SHIFT-1:0] == LATCH_SHIFT'(i)) begin
        next_s.latch[i] = bus.latch_data;
      end
    end
  end

  // latches come out of reset erased (all ones)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign bus.latches = s.latch;

endmodule

//--- hdl/flash_array.sv
`timescale 1ns/1ps
module flash_array import nvm_pkg::*; (
  input  wire logic aclk,
  input  wire logic aresetn,
  nvm_if.array      bus
);

  typedef struct packed {
    logic [ARRAY_WORDS-1:0][WORD_W-1:0] words; // stored program words
  } array_s;

  array_s                s;        // registered state
  array_s                next_s;   // next state
  logic [ADDR_LOW_W-1:0] row_base; // first word of the addressed row
  logic [ADDR_LOW_W-1:0] blk_base; // first word of the latch block

  assign row_base = {bus.word_addr[ADDR_LOW_W-1:ROW_SHIFT], ROW_SHIFT'(0)};
  assign blk_base = {bus.word_addr[ADDR_LOW_W-1:LATCH_SHIFT], LATCH_SHIFT'(0)};

  // erase sets a whole row; programming only clears bits, never erases
  always_comb begin
    next_s = s;
    if (bus.erase_go) begin
      for (int i = 0; i < ROW_WORDS; i++) begin
        next_s.words[row_base + ADDR_LOW_W'(i)] = ERASED_WORD;
      end
    end
    if (bus.prog_go) begin
      for (int i = 0; i < LATCHES; i++) begin
        // whole block written, unloaded latches included; and-ing models no auto erase
        next_s.words[blk_base + ADDR_LOW_W'(i)] =
          s.words[blk_base + ADDR_LOW_W'(i)] & bus.latches[i];
      end
    end
  end

  // contents are not retained across reset in this model: erased on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  // reads ignore code protection entirely
  assign bus.rd_data = s.words[bus.word_addr];

endmodule

//--- hdl/flash_self_program_ctrl.sv
`timescale 1ns/1ps
// Contract
// - flash read occurs in second cycle after trigger
// - read word lands next cycle, held until replaced
// - self reads ignore code protection
// - row erase needs selects, permit, unlock, launch
// - row erase select self-clears when erase ends
// - two setup cycles after launch are ignored
// - erase halts core about 2 ms, clocks run
// - core resumes third instruction after launch
// - programming never erases automatically
// - one program writes at most eight aligned latches
// - latches return to 3fff after programming
// - latch-only launch loads one latch, no stall
// - normal launch loads last latch, programs block
// - latch load and program each need unlock
// - whole latch block is programmed every time
// - block write halts only on final launch
// - triggers set by software, cleared by hardware
// - launch refused without permit; later clear harmless
// - rows 32 words, latch block 8 words aligned
// - unlock register reads as zero
module flash_self_program_ctrl import nvm_pkg::*; #(
  parameter int unsigned busy_cycles = BUSY_CYCLES // stall length, shorten in simulation
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [11:0] awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [11:0] araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        code_protect,
  output logic             cpu_hold,
  output logic             read_discard,
  output logic             nvm_done_flag
);

  localparam logic [COUNT_W-1:0] COUNT_LAST = COUNT_W'(busy_cycles - 1);

  typedef struct packed {
    logic                   awready;      // write address slot free
    logic                   aw_full;      // write address held
    logic [11:0]            aw_addr;      // held write address
    logic                   wready;       // write data slot free
    logic                   w_full;       // write data held
    logic [7:0]             w_data;       // held write byte
    logic                   w_en;         // low byte lane enabled
    logic                   bvalid;       // write response pending
    logic [1:0]             bresp;        // write response code
    logic                   arready;      // read address slot free
    logic                   rvalid;       // read data pending
    logic [31:0]            rdata;        // read data
    logic [1:0]             rresp;        // read response code
    logic [ADDR_LOW_W-1:0]  addr_low;     // nvm_addr_low
    logic [ADDR_HIGH_W-1:0] addr_high;    // nvm_addr_high
    logic [DATA_LOW_W-1:0]  data_low;     // nvm_data_low
    logic [DATA_HIGH_W-1:0] data_high;    // nvm_data_high
    logic [CTL_W-1:0]       ctl;          // nvm_control
    logic                   done;         // nvm_done_flag
    logic [1:0]             key_stage;    // unlock progress
    seq_state_e             state;        // sequencer state
    logic                   op_erase;     // running op is a row erase
    logic [COUNT_W-1:0]     count;        // stall cycle counter
    logic                   latch_load;   // pulse to latch bank
    logic                   latch_clear;  // pulse to latch bank
    logic                   erase_go;     // pulse to array
    logic                   prog_go;      // pulse to array
    logic                   cpu_hold;     // core halted
    logic                   read_discard; // instruction in this cycle dropped
    logic                   cp_meta;      // code_protect first sync stage
    logic                   cp_sync;      // code_protect synchronised
  } ctrl_s;

  ctrl_s       s;        // registered state
  ctrl_s       next_s;   // next state
  logic        aw_take;  // write address handshake
  logic        w_take;   // write data handshake
  logic        ar_take;  // read address handshake
  logic        wr_do;    // both write halves held, commit now
  logic        idle;     // sequencer free
  logic [7:0]  d;        // held write byte
  logic [31:0] rd_mux;   // register read value
  logic        rd_err;   // unmapped read

  nvm_if bus ();

  write_latch_bank u_latch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus     (bus.latch)
  );

  flash_array u_array (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus     (bus.array)
  );

  assign aw_take = awvalid && s.awready;
  assign w_take  = wvalid && s.wready;
  assign ar_take = arvalid && s.arready;
  assign wr_do   = s.aw_full && s.w_full && !s.bvalid;
  assign idle    = (s.state == ST_IDLE);
  assign d       = s.w_data;

  // read decode; unmapped offsets answer zero with slverr
  always_comb begin
    rd_mux = 32'h0;
    rd_err = 1'b0;
    if (araddr == OFS_ADDR_LOW) begin
      rd_mux = {24'h0, s.addr_low};
    end else if (araddr == OFS_ADDR_HIGH) begin
      rd_mux = {25'h0, s.addr_high};
    end else if (araddr == OFS_DATA_LOW) begin
      rd_mux = {24'h0, s.data_low};
    end else if (araddr == OFS_DATA_HIGH) begin
      rd_mux = {26'h0, s.data_high};
    end else if (araddr == OFS_CONTROL) begin
      rd_mux = {25'h0, s.ctl};
    end else if (araddr == OFS_UNLOCK) begin
      rd_mux = 32'h0;
    end else if (araddr == OFS_STATUS) begin
      rd_mux = {29'h0, s.cp_sync, !idle, s.done};
    end else begin
      rd_err = 1'b1;
    end
  end

  // bus slave first, sequencer after it so hardware updates win
  always_comb begin
    next_s              = s;
    next_s.latch_load   = 1'b0;
    next_s.latch_clear  = 1'b0;
    next_s.erase_go     = 1'b0;
    next_s.prog_go      = 1'b0;
    next_s.read_discard = 1'b0;
    next_s.cp_meta      = code_protect;
    next_s.cp_sync      = s.cp_meta;

    // capture write halves independently, in either order
    if (aw_take) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (w_take) begin
      next_s.w_full = 1'b1;
      next_s.w_data = wdata[7:0];
      next_s.w_en   = wstrb[0];
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end

    if (wr_do) begin
      next_s.aw_full   = 1'b0;
      next_s.w_full    = 1'b0;
      next_s.bvalid    = 1'b1;
      next_s.bresp     = RESP_OKAY;
      next_s.key_stage = KEY_NONE;
      if (s.aw_addr == OFS_ADDR_LOW) begin
        if (s.w_en) begin
          next_s.addr_low = d;
        end
      end else if (s.aw_addr == OFS_ADDR_HIGH) begin
        if (s.w_en) begin
          next_s.addr_high = d[ADDR_HIGH_W-1:0];
        end
      end else if (s.aw_addr == OFS_DATA_LOW) begin
        if (s.w_en) begin
          next_s.data_low = d;
        end
      end else if (s.aw_addr == OFS_DATA_HIGH) begin
        if (s.w_en) begin
          next_s.data_high = d[DATA_HIGH_W-1:0];
        end
      end else if (s.aw_addr == OFS_UNLOCK) begin
        // only an uninterrupted 55h, aah pair arms the launch
        if (s.w_en && d == UNLOCK_KEY1) begin
          next_s.key_stage = KEY_FIRST;
        end else if (s.w_en && d == UNLOCK_KEY2 && s.key_stage == KEY_FIRST) begin
          next_s.key_stage = KEY_ARMED;
        end
      end else if (s.aw_addr == OFS_STATUS) begin
        if (s.w_en && d[ST_DONE]) begin
          next_s.done = 1'b0;
        end
      end else if (s.aw_addr == OFS_CONTROL) begin
        if (s.w_en) begin
          // permit may drop at any time; the running op already took its copy
          next_s.ctl[CTL_PERMIT] = d[CTL_PERMIT];
          if (idle) begin
            // mode bits frozen while an operation is under way
            next_s.ctl[CTL_ERASE]      = d[CTL_ERASE];
            next_s.ctl[CTL_LATCH_ONLY] = d[CTL_LATCH_ONLY];
            next_s.ctl[CTL_CFG]        = d[CTL_CFG];
            next_s.ctl[CTL_PROG]       = d[CTL_PROG];
          end
          // triggers: writing zero does nothing, only hardware clears them
          if (d[CTL_READ] && idle && (s.ctl[CTL_PROG] || s.ctl[CTL_CFG])) begin
            next_s.ctl[CTL_READ] = 1'b1;
            next_s.state         = ST_RD_WAIT;
          end else if (d[CTL_LAUNCH] && idle && s.key_stage == KEY_ARMED
                       && s.ctl[CTL_PERMIT] && s.ctl[CTL_PROG] && !s.ctl[CTL_CFG]) begin
            next_s.ctl[CTL_LAUNCH] = 1'b1;
            if (s.ctl[CTL_LATCH_ONLY] && !s.ctl[CTL_ERASE]) begin
              next_s.latch_load = 1'b1;
            end else begin
              // erase or final block launch: stall through setup and the work
              next_s.op_erase   = s.ctl[CTL_ERASE];
              next_s.latch_load = !s.ctl[CTL_ERASE];
              next_s.state      = ST_SETUP1;
              next_s.cpu_hold   = 1'b1;
            end
          end
        end
      end else begin
        next_s.bresp = RESP_SLVERR;
      end
    end
    next_s.awready = !next_s.aw_full && !next_s.bvalid;
    next_s.wready  = !next_s.w_full && !next_s.bvalid;

    // read channel: one outstanding read, answered the cycle after the address
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_take) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_mux;
      next_s.rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    next_s.arready = !next_s.rvalid;

    // sequencer
    case (s.state)
      ST_IDLE: begin
        if (s.latch_load) begin
          next_s.ctl[CTL_LATCH_ONLY] = s.ctl[CTL_LATCH_ONLY];
          next_s.ctl[CTL_LAUNCH]     = 1'b0;
        end
      end
      ST_RD_WAIT: begin
        // first cycle after the trigger executes normally
        next_s.state        = ST_RD_DO;
        next_s.read_discard = 1'b1;
      end
      ST_RD_DO: begin
        // configuration space is not mapped here and reads back as zero
        next_s.data_low      = s.ctl[CTL_CFG] ? 8'h00 : bus.rd_data[DATA_LOW_W-1:0];
        next_s.data_high     = s.ctl[CTL_CFG] ? 6'h00 : bus.rd_data[WORD_W-1:DATA_LOW_W];
        next_s.ctl[CTL_READ] = 1'b0;
        next_s.state         = ST_IDLE;
      end
      ST_SETUP1: begin
        next_s.state = ST_SETUP2;
      end
      ST_SETUP2: begin
        next_s.state = ST_WORK;
        next_s.count = '0;
      end
      ST_WORK: begin
        if (s.count == COUNT_LAST) begin
          next_s.erase_go = s.op_erase;
          next_s.prog_go  = !s.op_erase;
          next_s.state    = ST_FINISH;
        end else begin
          next_s.count = s.count + COUNT_W'(1);
        end
      end
      ST_FINISH: begin
        next_s.ctl[CTL_LAUNCH] = 1'b0;
        if (s.op_erase) begin
          next_s.ctl[CTL_ERASE] = 1'b0;
        end else begin
          next_s.latch_clear = 1'b1;
        end
        next_s.done     = 1'b1;
        next_s.cpu_hold = 1'b0;
        next_s.state    = ST_IDLE;
      end
      default: begin
        next_s.state    = ST_IDLE;
        next_s.cpu_hold = 1'b0;
      end
    endcase
  end

  // register the whole state; handshake readies come up set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
      s.ctl     <= CTL_RESET;
      s.state   <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // the array and latches only see the low address byte
  assign bus.word_addr   = s.addr_low;
  assign bus.latch_data  = {s.data_high, s.data_low};
  assign bus.latch_load  = s.latch_load;
  assign bus.latch_clear = s.latch_clear;
  assign bus.erase_go    = s.erase_go;
  assign bus.prog_go     = s.prog_go;

  assign awready       = s.awready;
  assign wready        = s.wready;
  assign bvalid        = s.bvalid;
  assign bresp         = s.bresp;
  assign arready       = s.arready;
  assign rvalid        = s.rvalid;
  assign rdata         = s.rdata;
  assign rresp         = s.rresp;
  assign cpu_hold      = s.cpu_hold;
  assign read_discard  = s.read_discard;
  assign nvm_done_flag = s.done;

endmodule

//--- testbench/nvm_monitor.sv
`timescale 1ns/1ps
module nvm_monitor import nvm_pkg::*; #(
  parameter int unsigned busy_cycles = 10 // halt length of the instance
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        arvalid,
  input  wire logic        arready,
  input  wire logic [11:0] araddr,
  input  wire logic        rvalid,
  input  wire logic        rready,
  input  wire logic [31:0] rdata,
  input  wire logic        bvalid,
  input  wire logic        cpu_hold,
  input  wire logic        read_discard,
  input  wire logic        nvm_done_flag
);
  logic [11:0] ar_q;     // address of the read in flight
  logic [7:0]  hold_cnt; // cycles of the present halt, short halts only
  // helper state for the read address and the halt length
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_q     <= 12'h000;
      hold_cnt <= 8'h00;
    end else begin
      if (arvalid && arready) ar_q <= araddr;
      hold_cnt <= cpu_hold ? hold_cnt + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a register write commits on the edge where bvalid rises
  sequence s_commit; $rose(bvalid); endsequence
  sequence s_halt_end; $fell(cpu_hold); endsequence
  a_halt_length: assert property (s_halt_end |->
    hold_cnt >= busy_cycles + 2 && hold_cnt <= busy_cycles + 4) else $error("halt length off");
  a_halt_cause: assert property ($rose(cpu_hold) |-> s_commit)
    else $error("halt without launch write");
  a_done_at_end: assert property ($rose(nvm_done_flag) |-> s_halt_end)
    else $error("done flag not at halt end");
  a_done_sticky: assert property ($fell(nvm_done_flag) |-> s_commit)
    else $error("done flag dropped by itself");
  a_discard_pulse: assert property (read_discard |=> !read_discard)
    else $error("discard longer than one cycle");
  a_discard_cause: assert property (read_discard |-> $past(bvalid) && !cpu_hold)
    else $error("discard without trigger");
  a_unlock_zero: assert property (rvalid && ar_q == OFS_UNLOCK |-> rdata == 32'h0)
    else $error("unlock register read nonzero");
  a_read_stable: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data moved while held");
endmodule
bind flash_self_program_ctrl nvm_monitor #(.busy_cycles(busy_cycles)) u_mon (.aclk, .aresetn,
  .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .bvalid, .cpu_hold, .read_discard,
  .nvm_done_flag);

//--- testbench/cpu_model.sv
`timescale 1ns/1ps
// software on the core, reaching the block as an axi4-lite master
module cpu_model import nvm_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        awready,
  input  wire logic        wready,
  input  wire logic        bvalid,
  input  wire logic        arready,
  input  wire logic        rvalid,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  output logic             awvalid,
  output logic [11:0]      awaddr,
  output logic             wvalid,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             bready,
  output logic             arvalid,
  output logic [11:0]      araddr,
  output logic             rready
);
  // idle bus at time zero
  initial begin
    {awvalid, awaddr, wvalid, wdata, wstrb, bready, arvalid, araddr, rready} = 65'h0;
  end
  // one write; each half is dropped once its ready is seen
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= {24'h000000, d};
    wstrb   <= 4'hf;
    bready  <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      got = bvalid;
    end
    bready <= 1'b0;
  endtask
  // one read; rready trails rvalid a cycle so a held answer is seen
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    while (!got) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      got = rvalid && rready;
      if (!got) rready <= rvalid;
      d = rdata;
      r = rresp;
    end
    rready <= 1'b0;
  endtask
  // mode set, keys back to back, launch, then two idle slots
  task automatic launch(input logic [7:0] ctl);
    wr(OFS_CONTROL, ctl);
    wr(OFS_UNLOCK, UNLOCK_KEY1);
    wr(OFS_UNLOCK, UNLOCK_KEY2);
    wr(OFS_CONTROL, ctl | 8'h02);
    repeat (2) @(posedge aclk);
  endtask
  // address and data pair for one latch
  task automatic ldw(input logic [7:0] adr, input word_t v);
    wr(OFS_ADDR_LOW, adr);
    wr(OFS_DATA_LOW, v[7:0]);
    wr(OFS_DATA_HIGH, {2'h0, v[13:8]});
  endtask
  // flash read with two idle slots after the trigger
  task automatic fread(input logic [7:0] adr, output word_t w);
    logic [31:0] lo;
    logic [31:0] hi;
    logic [1:0]  r;
    wr(OFS_ADDR_LOW, adr);
    wr(OFS_CONTROL, 8'h41);
    repeat (2) @(posedge aclk);
    rd(OFS_DATA_LOW, lo, r);
    rd(OFS_DATA_HIGH, hi, r);
    w = {hi[5:0], lo[7:0]};
  endtask
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb import nvm_pkg::*;;
  localparam int unsigned busy = 10; // shortened halt
  typedef struct packed {logic [11:0] a; logic [7:0] d; logic [31:0] q; logic [1:0] r;} row_s;
  logic        aclk = 1'b0;
  logic        aresetn, code_protect, hold_q;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic        rvalid, rready, cpu_hold, read_discard, nvm_done_flag;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [31:0] halts = 0, discards = 0, failures = 0, tests_run = 0;
  // write, read back, expected data and response
  row_s rows [7] = '{'{OFS_ADDR_LOW, 8'ha5, 32'ha5, RESP_OKAY},
    '{OFS_ADDR_HIGH, 8'hff, 32'h7f, RESP_OKAY}, '{OFS_DATA_LOW, 8'h5a, 32'h5a, RESP_OKAY},
    '{OFS_DATA_HIGH, 8'hff, 32'h3f, RESP_OKAY}, '{OFS_UNLOCK, 8'h55, 32'h0, RESP_OKAY},
    '{OFS_CONTROL, 8'h0e, 32'h0c, RESP_OKAY}, '{12'h01c, 8'h12, 32'h0, RESP_SLVERR}};
  always #5 aclk = ~aclk;
  flash_self_program_ctrl #(.busy_cycles(busy)) u_dut (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .code_protect, .cpu_hold, .read_discard,
    .nvm_done_flag);
  cpu_model u_cpu (.aclk, .awready, .wready, .bvalid, .arready, .rvalid, .rdata, .rresp,
    .awvalid, .awaddr, .wvalid, .wdata, .wstrb, .bready, .arvalid, .araddr, .rready);
  // count halts and dropped instructions seen at the pins
  always @(posedge aclk) begin
    hold_q <= cpu_hold;
    if (cpu_hold && !hold_q) halts <= halts + 1;
    if (read_discard) discards <= discards + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // wait out a halt, then see the done flag and clear it
  task automatic finish_op;
    while (cpu_hold) @(negedge aclk);
    check(nvm_done_flag, 1);
    u_cpu.wr(OFS_STATUS, 8'h01);
    check(nvm_done_flag, 0);
  endtask
  // ample for a few hundred bus cycles and four short halts
  initial begin
    #300us;
    failures++;
    close_out();
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    word_t       w;
    aresetn = 1'b0;
    code_protect = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      u_cpu.wr(rows[i].a, rows[i].d);
      check(32'(bresp), 32'(rows[i].r));
      u_cpu.rd(rows[i].a, d, r);
      check(d, rows[i].q);
      check(32'(r), 32'(rows[i].r));
    end
    $display("table done");
    // broken key order, then a launch without permit: both refused
    u_cpu.wr(OFS_CONTROL, 8'h4c);
    u_cpu.wr(OFS_UNLOCK, UNLOCK_KEY1);
    u_cpu.wr(OFS_ADDR_LOW, 8'h00);
    u_cpu.wr(OFS_UNLOCK, UNLOCK_KEY2);
    u_cpu.wr(OFS_CONTROL, 8'h4e);
    u_cpu.launch(8'h40);
    check(halts, 0);
    $display("refusals done");
    // latch-only load, then the final launch programs the block
    u_cpu.ldw(8'h08, 14'h1234);
    u_cpu.launch(8'h54);
    check(halts, 0);
    u_cpu.ldw(8'h0f, 14'h0abc);
    u_cpu.launch(8'h44);
    finish_op();
    check(halts, 1);
    code_protect <= 1'b1;
    u_cpu.fread(8'h08, w);
    check(32'(w), 32'h1234);
    u_cpu.fread(8'h09, w);
    check(32'(w), 32'h3fff);
    u_cpu.fread(8'h0f, w);
    check(32'(w), 32'h0abc);
    check(discards, 3);
    // a fresh block must not see stale latches
    u_cpu.ldw(8'h27, 14'h0ff0);
    u_cpu.launch(8'h44);
    finish_op();
    u_cpu.fread(8'h20, w);
    check(32'(w), 32'h3fff);
    u_cpu.fread(8'h27, w);
    check(32'(w), 32'h0ff0);
    $display("block write done");
    // row erase from a mid-row address
    u_cpu.wr(OFS_ADDR_LOW, 8'h0d);
    u_cpu.launch(8'h4c);
    finish_op();
    u_cpu.rd(OFS_CONTROL, d, r);
    check(d, 32'h44);
    u_cpu.fread(8'h0f, w);
    check(32'(w), 32'h3fff);
    u_cpu.fread(8'h27, w);
    check(32'(w), 32'h0ff0);
    check(halts, 3);
    $display("row erase done");
    // reset after an erase clears control and the done flag
    u_cpu.launch(8'h4c);
    while (cpu_hold) @(negedge aclk);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    u_cpu.rd(OFS_CONTROL, d, r);
    check(d, 32'h0);
    check(nvm_done_flag, 0);
    $display("reset done");
    close_out();
  end
endmodule
